// file: hw/pwpm_pkg.sv
// package for the pulse width / period meter: register map, field layouts,
// reset values and timing constants.
// assumes a 40 MHz system clock that also serves as the meter's input clock.
package pwpm_pkg;

  // register byte offsets on the avalon slave
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_PRESC   = 5'h04;
  localparam logic [4:0] OFS_RESULT  = 5'h08;
  localparam logic [4:0] OFS_STATUS  = 5'h0c;
  localparam logic [4:0] OFS_MASK    = 5'h10;
  localparam logic [4:0] OFS_STATE   = 5'h14;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int DIV_W  = 20;
  localparam int PIN_N  = 4;

  // control register layout, bit 7 downward
  typedef struct packed {
    logic       preserve;   // bit 7
    logic       route_ded;  // bit 6
    logic [1:0] pin_sel;    // bits 5:4
    logic       newer;      // bit 3
    logic       invert;     // bit 2
    logic       period;     // bit 1
    logic       enable;     // bit 0
  } pwpm_cfg_t;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // status, mask and interrupt layout
  typedef struct packed {
    logic ovf;   // bit 1
    logic newm;  // bit 0
  } pwpm_evt_t;
  localparam int EVT_W = 2;

  // prescaler codes
  localparam logic [3:0] PRESC_OLD_MASK = 4'h7;
  localparam logic [3:0] PRESC_DECL_DEF = 4'h0;

  // count-clock scaling
  localparam int SCALE   = 2000;
  localparam int CLK_MHZ = 40;
  localparam int REF_MHZ = 10;
  localparam int OLD_BASE_CYC = SCALE / 1000;
  localparam int NEW_BASE_CYC = SCALE * CLK_MHZ / (REF_MHZ * 1000);

  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

  // typical result read latency of the older variant
  localparam int T_FIN_NS     = 86000;
  localparam int T_RET_NEW_NS = 52000;
  localparam int T_RET_OLD_NS = 22000;
  localparam int T_FIN_CYC     = T_FIN_NS * CLK_MHZ / 1000;
  localparam int T_RET_NEW_CYC = T_RET_NEW_NS * CLK_MHZ / 1000;
  localparam int T_RET_OLD_CYC = T_RET_OLD_NS * CLK_MHZ / 1000;

endpackage

// file: hw/pwpm_meter.sv
// pulse width / period meter with avalon-mm register slave and interrupt.
// assumes one 40 MHz clock, synchronous reset, and asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none

module pwpm_meter #(
  parameter logic [3:0] DECL_PRESC  = pwpm_pkg::PRESC_DECL_DEF,
  parameter int         FIN_CYC     = pwpm_pkg::T_FIN_CYC,
  parameter int         RET_NEW_CYC = pwpm_pkg::T_RET_NEW_CYC,
  parameter int         RET_OLD_CYC = pwpm_pkg::T_RET_OLD_CYC
) (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  input  wire logic [pwpm_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [pwpm_pkg::DATA_W-1:0]   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic [pwpm_pkg::DATA_W-1:0]        avs_readdata_o,
  output logic                               avs_waitrequest_o,
  input  wire logic [pwpm_pkg::PIN_N-1:0]    timer_pin_i,
  output logic                               irq_o
);

  localparam int LAT_W = 16;

  pwpm_pkg::pwpm_cfg_t               cfg;
  logic [3:0]                        presc_rt;
  logic                              presc_ovr;
  pwpm_pkg::pwpm_evt_t               sts;
  pwpm_pkg::pwpm_evt_t               mask;
  logic [pwpm_pkg::CNT_W-1:0]        result;
  logic [pwpm_pkg::CNT_W-1:0]        count;
  logic [pwpm_pkg::DIV_W-1:0]        div_cnt;
  logic [pwpm_pkg::PIN_N-1:0]        pin_s1;
  logic [pwpm_pkg::PIN_N-1:0]        pin_s2;
  logic                              lvl_q;
  logic                              ovf_hold;
  logic                              ovf_done;
  logic                              ack;
  logic                              lat_busy;
  logic [LAT_W-1:0]                  lat_cnt;
  logic                              pending;
  logic                              cfg_seam;

  logic                              req;
  logic                              wr_take;
  logic                              rd_take;
  logic                              rd_result;
  logic [3:0]                        presc_eff;
  logic [pwpm_pkg::DIV_W-1:0]        div_lim;
  logic                              tick;
  logic                              lvl;
  logic                              active;
  logic                              edge_hit;
  logic                              done;
  logic                              ovf_evt;
  logic                              ded_eff;
  pwpm_pkg::pwpm_evt_t               set_evt;
  logic [LAT_W-1:0]                  lat_load;
  logic [pwpm_pkg::DATA_W-1:0]       next_rdata;
  logic [pwpm_pkg::CNT_W-1:0]        capt;

  // avalon handshake
  assign req       = avs_read_i | avs_write_i;
  assign wr_take   = avs_write_i & ack;
  assign rd_take   = avs_read_i & ack;
  assign rd_result = rd_take & (avs_address_i == pwpm_pkg::OFS_RESULT);
  assign avs_waitrequest_o = req & ~ack;

  // the long wait mimics the firmware read path, so only result reads pay it
  assign lat_load = cfg.newer ? '0
                  : LAT_W'(FIN_CYC + (pending ? RET_NEW_CYC : RET_OLD_CYC) - 1);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ack      <= 1'b0;
      lat_busy <= 1'b0;
      lat_cnt  <= '0;
    end
    else if (ack)
    begin
      ack <= 1'b0;
    end
    else if (lat_busy)
    begin
      if (lat_cnt == '0)
      begin
        lat_busy <= 1'b0;
        ack      <= 1'b1;
      end
      else
      begin
        lat_cnt <= lat_cnt - 1'b1;
      end
    end
    else if (req)
    begin
      if (avs_read_i && avs_address_i == pwpm_pkg::OFS_RESULT && !cfg.newer)
      begin
        lat_busy <= 1'b1;
        lat_cnt  <= lat_load;
      end
      else
      begin
        ack <= 1'b1;
      end
    end
  end

  // read mux, registered as the answer is given
  always_comb
  begin
    next_rdata = '0;
    case (avs_address_i)
      pwpm_pkg::OFS_CTRL:   next_rdata[7:0] = cfg;
      pwpm_pkg::OFS_PRESC:  next_rdata[4:0] = {presc_ovr, presc_eff};
      pwpm_pkg::OFS_RESULT: next_rdata[pwpm_pkg::CNT_W-1:0] = result;
      pwpm_pkg::OFS_STATUS: next_rdata[pwpm_pkg::EVT_W-1:0] = sts;
      pwpm_pkg::OFS_MASK:   next_rdata[pwpm_pkg::EVT_W-1:0] = mask;
      pwpm_pkg::OFS_STATE:  next_rdata[pwpm_pkg::CNT_W+2:0] = {ded_eff, ovf_hold, lvl, count};
      default:              next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      avs_readdata_o <= '0;
    else if (req && !ack && (!lat_busy || lat_cnt == '0))
      avs_readdata_o <= next_rdata;
  end

  // control and prescaler registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cfg <= pwpm_pkg::CTRL_RST;
    else if (wr_take && avs_address_i == pwpm_pkg::OFS_CTRL && avs_byteenable_i[0])
      cfg <= avs_writedata_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      presc_rt  <= '0;
      presc_ovr <= 1'b0;
    end
    else if (wr_take && avs_address_i == pwpm_pkg::OFS_PRESC && avs_byteenable_i[0])
    begin
      presc_rt  <= avs_writedata_i[3:0];
      presc_ovr <= 1'b1;
    end
  end

  // older variant only honours the lower eight codes
  assign presc_eff = (presc_ovr ? presc_rt : DECL_PRESC & pwpm_pkg::PRESC_OLD_MASK)
                   & (cfg.newer ? 4'hf : pwpm_pkg::PRESC_OLD_MASK);

  // count clock period in system cycles
  assign div_lim = cfg.newer
                 ? pwpm_pkg::DIV_W'(pwpm_pkg::NEW_BASE_CYC) << presc_eff
                 : pwpm_pkg::DIV_W'(pwpm_pkg::OLD_BASE_CYC) << presc_eff;

  // pin synchroniser, every pin sampled each clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= timer_pin_i;
      pin_s2 <= pin_s1;
    end
  end

  // only pin 0 can reach the dedicated timer
  assign ded_eff = cfg.route_ded & (cfg.pin_sel == 2'h0);
  assign lvl     = pin_s2[cfg.pin_sel];

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      lvl_q <= 1'b0;
    else
      lvl_q <= lvl;
  end

  // a ctrl write may swap pin or polarity, so lvl_q briefly holds a foreign level;
  // the count restarts there too, so the first result is partial when a period or an active pulse spans the switch
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      cfg_seam <= 1'b0;
    else
      cfg_seam <= wr_take && (avs_address_i == pwpm_pkg::OFS_CTRL) && avs_byteenable_i[0];
  end

  assign active   = lvl ^ cfg.invert;
  assign edge_hit = cfg.invert ? (lvl & ~lvl_q) : (~lvl & lvl_q);

  // divider restarts with each measurement so the first unit is whole
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !cfg.enable || cfg_seam)
      div_cnt <= '0;
    else if ((cfg.period && edge_hit) || (!cfg.period && !active))
      div_cnt <= '0;
    else if (div_cnt >= div_lim - 1'b1)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  assign tick = cfg.enable && (div_cnt >= div_lim - 1'b1)
              && (cfg.period || active);

  // measurement end and overflow events
  assign done = cfg.enable && !cfg_seam
              && (cfg.period ? edge_hit : (lvl_q ^ cfg.invert) && !active);
  assign ovf_evt = cfg.enable && !done && tick && count == pwpm_pkg::CNT_MAX && !ovf_done;

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !cfg.enable || cfg_seam)
    begin
      count    <= '0;
      ovf_done <= 1'b0;
    end
    else if (done)
    begin
      count    <= '0;
      ovf_done <= 1'b0;
    end
    else if (ovf_evt)
    begin
      ovf_done <= 1'b1;
    end
    else if (tick && count != pwpm_pkg::CNT_MAX)
    begin
      count <= count + 1'b1;
    end
  end

  // above setting 0 the unit that ends on the edge is whole, so it counts
  always_comb
  begin
    capt = count;
    if (cfg.period && tick && presc_eff != '0 && count != pwpm_pkg::CNT_MAX)
      capt = count + 1'b1;
  end

  // edge cycle itself is not counted at setting 0, software adds n
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      result <= '0;
    else if (ovf_evt)
      result <= pwpm_pkg::CNT_MAX;
    else if (done && !ovf_done)
      result <= capt;
  end

  // overflow state holds until the result is read
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      ovf_hold <= 1'b0;
    else if (ovf_evt)
      ovf_hold <= 1'b1;
    else if (rd_result)
      ovf_hold <= 1'b0;
  end

  assign set_evt.newm = done && !ovf_done && (!ovf_hold || cfg.preserve);
  assign set_evt.ovf  = ovf_evt;

  // pending result drives the longer return time
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pending <= 1'b0;
    else if (set_evt.newm)
      pending <= 1'b1;
    else if (rd_result)
      pending <= 1'b0;
  end

  // sticky status, set wins over write-one-clear and read-clear
  genvar gi;
  generate
    for (gi = 0; gi < pwpm_pkg::EVT_W; gi++)
    begin : g_sts
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          sts[gi] <= 1'b0;
        else if (set_evt[gi])
          sts[gi] <= 1'b1;
        else if (wr_take && avs_address_i == pwpm_pkg::OFS_STATUS && avs_writedata_i[gi])
          sts[gi] <= 1'b0;
        else if (gi == 0 && rd_result)
          sts[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      mask <= '0;
    else if (wr_take && avs_address_i == pwpm_pkg::OFS_MASK && avs_byteenable_i[0])
      mask <= avs_writedata_i[pwpm_pkg::EVT_W-1:0];
  end

  assign irq_o = |(sts & mask);

endmodule

`default_nettype wire

// file: dv/pwpm_meter_sva.sv
// checker on the meter's bus and interrupt ports.
// assumes a bind onto pwpm_meter run with short latency parameters.
`timescale 1ns/1ps
`default_nettype none
module pwpm_meter_sva #(
  parameter int FIN_CYC     = 20,
  parameter int RET_NEW_CYC = 10
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  input  wire logic        irq_o
);
  localparam int LAT_MAX = FIN_CYC + RET_NEW_CYC + 1;
  logic       older;
  logic [1:0] mask;
  wire        take   = !avs_waitrequest_o && (avs_read_i || avs_write_i);
  wire        rd_res = avs_read_i && avs_address_i == pwpm_pkg::OFS_RESULT;
  // shadow of the two fields the latency and irq checks depend on
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      older <= 1'h1;
      mask  <= 2'h0;
    end
    else if (take && avs_write_i && avs_byteenable_i[0])
    begin
      if (avs_address_i == pwpm_pkg::OFS_CTRL)
        older <= !avs_writedata_i[3];
      if (avs_address_i == pwpm_pkg::OFS_MASK)
        mask <= avs_writedata_i[1:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  chk_res_unsigned: assert property (rd_res && !avs_waitrequest_o |->
    avs_readdata_o[31:16] == 16'h0) else $error("result upper bits set");
  chk_wr_answer: assert property ($rose(avs_write_i) |=> !avs_waitrequest_o)
    else $error("write not answered in one cycle");
  chk_wait_once: assert property (take |=>
    avs_waitrequest_o || !(avs_read_i || avs_write_i)) else $error("answer held too long");
  chk_old_hold: assert property ($rose(rd_res) && older |->
    avs_waitrequest_o [*8]) else $error("older result read answered early");
  chk_old_bound: assert property ($rose(rd_res) && older |->
    ##[1:LAT_MAX] !avs_waitrequest_o) else $error("older result read too slow");
  chk_fast_read: assert property ($rose(avs_read_i) && !(rd_res && older) |=>
    !avs_waitrequest_o) else $error("read not answered in one cycle");
  chk_irq_masked: assert property (take && avs_write_i && avs_byteenable_i[0] &&
    avs_address_i == pwpm_pkg::OFS_MASK && avs_writedata_i[1:0] == 2'h0 |=> !irq_o)
    else $error("irq high with mask cleared");
  chk_irq_mask: assert property (irq_o |-> mask != 2'h0)
    else $error("irq without mask bit");
endmodule
bind pwpm_meter pwpm_meter_sva #(.FIN_CYC(FIN_CYC), .RET_NEW_CYC(RET_NEW_CYC))
  pwpm_meter_sva_inst (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
`default_nettype wire

// file: dv/pwpm_wave_src.sv
// waveform source standing in for the sensor on the four timer pins.
// assumes calls are made just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pwpm_wave_src (
  input  wire logic       clk_i,
  output var  logic [3:0] pin_o
);
  initial pin_o = 4'h0;
  // pins are always driven, so no floating level to model
  task automatic drive(input int idx, input logic lvl, input int cyc);
    pin_o[idx] <= lvl;
    repeat (cyc) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: dv/pulse_width_period_meter_tb_top.sv
// self-checking bench for the pulse width / period meter.
// assumes the design, its checker bind and the waveform source.
`timescale 1ns/1ps
`default_nettype none
module pulse_width_period_meter_tb_top;
  localparam int FIN = 20;
  localparam int RN  = 10;
  localparam int RO  = 5;
  logic        clk_i  = 1'h0;
  logic        srst_i = 1'h1;
  logic [4:0]  adr    = 5'h0;
  logic        rd     = 1'h0;
  logic        wr     = 1'h0;
  logic [31:0] wdat   = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  logic        irq;
  logic [3:0]  pins;
  logic [31:0] d;
  logic [31:0] pcfg [3] = '{32'h4b, 32'h4f, 32'h43};
  // n is 1 at setting 0, so one unit under the 2 us period
  logic [31:0] pexp [3] = '{32'h9, 32'h9, 32'h27};
  int          lat;
  int          fails       = 0;
  int          comparisons = 0;
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  pwpm_meter #(.FIN_CYC(FIN), .RET_NEW_CYC(RN), .RET_OLD_CYC(RO)) pwpm_meter_inst (
    .clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .timer_pin_i(pins), .irq_o(irq));
  pwpm_wave_src pwpm_wave_src_inst (.clk_i(clk_i), .pin_o(pins));
  // one access; an idle edge follows so the strobe never toggles twice in a step
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v);
    adr  <= a;
    wdat <= v;
    rd   <= !w;
    wr   <= w;
    lat = 0;
    do
    begin
      @(posedge clk_i);
      lat++;
    end
    while (wreq !== 1'h0 && lat < 5000);
    if (wreq !== 1'h0)
    begin
      fails++;
      $display("[ERR] waitrequest expected 0 seen %h", wreq);
    end
    d = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
    @(posedge clk_i);
  endtask
  // width counts are exact; period counts at setting 0 read one unit under, as the edge cycle is not counted
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    fails++;
    report_and_stop;
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'h0;
    @(posedge clk_i);
    bus(1'h0, pwpm_pkg::OFS_PRESC, 32'h0);
    chk("presc default", 32'h0, d);
    bus(1'h0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, d);
    bus(1'h1, pwpm_pkg::OFS_MASK, 32'h1);
    bus(1'h1, pwpm_pkg::OFS_CTRL, 32'h1);
    pwpm_wave_src_inst.drive(0, 1'h1, 40);
    pwpm_wave_src_inst.drive(0, 1'h0, 30);
    chk("irq set", 32'h1, {31'h0, irq});
    bus(1'h0, pwpm_pkg::OFS_RESULT, 32'h0);
    chk("high time", 32'h14, d);
    chk("lat new", FIN + RN + 2, lat);
    chk("irq clear", 32'h0, {31'h0, irq});
    bus(1'h0, pwpm_pkg::OFS_RESULT, 32'h0);
    chk("lat old", FIN + RO + 2, lat);
    $display("high time test done");
    pwpm_wave_src_inst.drive(2, 1'h1, 4);
    bus(1'h1, pwpm_pkg::OFS_MASK, 32'h0);
    bus(1'h1, pwpm_pkg::OFS_PRESC, 32'h1);
    bus(1'h1, pwpm_pkg::OFS_CTRL, 32'h6d);
    bus(1'h0, pwpm_pkg::OFS_PRESC, 32'h0);
    chk("presc override", 32'h11, d);
    bus(1'h0, pwpm_pkg::OFS_STATE, 32'h0);
    chk("pin level", 32'h1, {31'h0, d[16]});
    chk("mux route", 32'h0, {31'h0, d[18]});
    bus(1'h0, pwpm_pkg::OFS_STATUS, 32'h0);
    chk("no seam event", 32'h0, d);
    pwpm_wave_src_inst.drive(2, 1'h0, 160);
    pwpm_wave_src_inst.drive(2, 1'h1, 30);
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(1'h0, pwpm_pkg::OFS_STATUS, 32'h0);
    chk("status new", 32'h1, d);
    bus(1'h1, pwpm_pkg::OFS_STATUS, 32'h1);
    bus(1'h0, pwpm_pkg::OFS_STATUS, 32'h0);
    chk("status w1c", 32'h0, d);
    bus(1'h0, pwpm_pkg::OFS_RESULT, 32'h0);
    chk("low time", 32'ha, d);
    $display("low time test done");
    bus(1'h1, pwpm_pkg::OFS_PRESC, 32'h0);
    foreach (pcfg[i])
    begin
      bus(1'h1, pwpm_pkg::OFS_CTRL, pcfg[i]);
      bus(1'h0, pwpm_pkg::OFS_STATE, 32'h0);
      chk("ded route", 32'h1, {31'h0, d[18]});
      repeat (3)
      begin
        pwpm_wave_src_inst.drive(0, 1'h1, 40);
        pwpm_wave_src_inst.drive(0, 1'h0, 40);
      end
      bus(1'h0, pwpm_pkg::OFS_RESULT, 32'h0);
      chk("period", pexp[i], d);
    end
    bus(1'h1, pwpm_pkg::OFS_PRESC, 32'h1);
    repeat (3)
    begin
      pwpm_wave_src_inst.drive(0, 1'h1, 40);
      pwpm_wave_src_inst.drive(0, 1'h0, 40);
    end
    bus(1'h0, pwpm_pkg::OFS_RESULT, 32'h0);
    chk("period n0", 32'h14, d);
    $display("period test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
